// ===== design/lcmu_defines.vh
`ifndef LCMU_DEFINES_VH
`define LCMU_DEFINES_VH

// ====================================================================
// channel and buffer geometry
`define LCMU_LOG_CHANNELS 6
`define LCMU_LINES 16
`define LCMU_LINE_AW 4
`define LCMU_SLOTS 14
`define LCMU_SLOT_W 8

// ====================================================================
// slot descriptor fields
`define LCMU_SLOT_LINE_LSB 0
`define LCMU_SLOT_CH_LSB 4
`define LCMU_SLOT_LOW_BIT 7

// ====================================================================
// function codes
`define LCMU_FN_ADD 3'h0
`define LCMU_FN_INT_ADD 3'h1
`define LCMU_FN_MUL 3'h2
`define LCMU_FN_INT_MUL 3'h3
`define LCMU_FN_CMP 3'h4
`define LCMU_FN_HYST 3'h5

// ====================================================================
// source selector: 0..5 logical, 8 and up physical
`define LCMU_SRC_PHYS_BIT 3

// ====================================================================
// reset values
`define LCMU_RESULT_RST 32'h0000_0000
`define LCMU_COUNT_RST 8'h00
`define LCMU_PRESCALE_RST 8'h00

`endif

// ===== design/lcmu_line_buffer.v
`timescale 1ns/10ps
`default_nettype none

// shift buffer of sample lines with registered read port
module lcmu_line_buffer #(
	parameter WIDTH = 32,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// clock and reset
	input wire clock,
	input wire rst_b,
	// shift side
	input wire shift_en,
	input wire [WIDTH-1:0] din,
	// read side
	input wire [AW-1:0] rd_addr,
	output reg [WIDTH-1:0] rd_data_reg,
	output reg [DEPTH-1:0] bits_reg
);

	reg [WIDTH-1:0] line_reg [0:DEPTH-1];
	integer i, j;

	// ================================================================
	// line storage
	always @(posedge clock) begin
		if (!rst_b) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				line_reg[i] <= {WIDTH{1'b0}};
			end
		end else if (shift_en) begin
			line_reg[0] <= din;
			for (i = 1; i < DEPTH; i = i + 1) begin
				line_reg[i] <= line_reg[i-1];
			end
		end
	end

	// ================================================================
	// read port
	always @(posedge clock) begin
		if (!rst_b) begin
			rd_data_reg <= {WIDTH{1'b0}};
			bits_reg <= {DEPTH{1'b0}};
		end else begin
			rd_data_reg <= line_reg[rd_addr];
			for (j = 0; j < DEPTH; j = j + 1) begin
				bits_reg[j] <= line_reg[j][0];
			end
		end
	end

endmodule // lcmu_line_buffer

`default_nettype wire

// ===== design/lcmu_top.v
`include "lcmu_defines.vh"
`timescale 1ns/10ps
`default_nettype none

module lcmu_top #(
	parameter PHYS_CH = 2,
	parameter NCH = `LCMU_LOG_CHANNELS,
	parameter NSLOT = `LCMU_SLOTS
) (
	// clock and reset
	input wire clock,
	input wire rst_b,
	// sampling input
	input wire sample_tick,
	input wire [7:0] prescaler,
	input wire [PHYS_CH*16-1:0] phys_values,
	// channel configuration
	input wire [NCH*3-1:0] function_select,
	input wire [NCH*8-1:0] logical_source_select,
	input wire [NCH*64-1:0] logical_function_parameter,
	input wire [NCH-1:0] wide32_select,
	// transfer slots
	input wire [NSLOT*`LCMU_SLOT_W-1:0] slot_map,
	input wire frame_req,
	output reg [15:0] frame_word_reg,
	output reg frame_valid_reg,
	output reg frame_last_reg,
	output reg [7:0] sample_update_counter_reg,
	output reg busy_reg
);

	localparam EX_IDLE = 2'h0;
	localparam EX_EVAL = 2'h1;
	localparam EX_SHIFT = 2'h2;
	localparam FR_IDLE = 2'h0;
	localparam FR_FETCH = 2'h1;
	localparam FR_EMIT = 2'h2;

	reg [1:0] ex_state_reg;
	reg [2:0] ch_reg;
	reg [7:0] pre_cnt_reg;
	reg exec_pend_reg;
	reg missed_reg;
	reg [31:0] res_reg [0:NCH-1];
	reg [1:0] fr_state_reg;
	reg [3:0] slot_idx_reg;
	reg frame_pend_reg;
	reg [31:0] new_res;
	reg signed [15:0] src0;
	reg signed [15:0] src1;
	reg [2:0] fn;
	reg [7:0] sel;
	reg signed [31:0] par0;
	reg signed [31:0] par1;
	reg signed [47:0] prod0;
	reg signed [47:0] prod1;
	reg signed [63:0] mprod;
	reg [31:0] add_term;
	reg [31:0] mul_term;
	reg [`LCMU_SLOT_W-1:0] slot;
	reg [2:0] slot_ch;
	reg [15:0] slot_word;
	wire [31:0] rd_data [0:NCH-1];
	wire [15:0] bits [0:NCH-1];
	wire exec_tick;
	wire shift_en;
	integer k, j;

	// ================================================================
	// per-channel buffers
	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1) begin : g_buf
			lcmu_line_buffer #(
				.WIDTH(32),
				.DEPTH(`LCMU_LINES),
				.AW(`LCMU_LINE_AW)
			) u_buf (
				.clock(clock),
				.rst_b(rst_b),
				.shift_en(shift_en),
				.din(res_reg[g]),
				.rd_addr(slot[`LCMU_SLOT_LINE_LSB +: `LCMU_LINE_AW]),
				.rd_data_reg(rd_data[g]),
				.bits_reg(bits[g])
			);
		end
	endgenerate

	// ================================================================
	// prescaler
	// divide sampling ticks
	assign exec_tick = sample_tick &&
		({1'b0, pre_cnt_reg} + 9'h001 >= {1'b0, prescaler});
	assign shift_en = (ex_state_reg == EX_SHIFT);

	always @(posedge clock) begin
		if (!rst_b) begin
			pre_cnt_reg <= `LCMU_PRESCALE_RST;
		end else if (exec_tick) begin
			pre_cnt_reg <= `LCMU_PRESCALE_RST;
		end else if (sample_tick) begin
			pre_cnt_reg <= pre_cnt_reg + 8'h01;
		end
	end

	// ================================================================
	// source selection and function datapath
	function [15:0] pick;
		input [7:0] s;
		input [PHYS_CH*16-1:0] pv;
		input [31:0] lres;
		input [2:0] lfn;
		begin
			if (s[`LCMU_SRC_PHYS_BIT]) begin
				if ({5'h00, s[2:0]} < PHYS_CH)
					pick = pv[s[2:0]*16 +: 16];
				else
					pick = 16'h0000;
			end else if (lfn == `LCMU_FN_CMP || lfn == `LCMU_FN_HYST) begin
				pick = {15'h0000, lres[0]};
			end else begin
				pick = lres[31:16];
			end
		end
	endfunction

	always @* begin
		fn = function_select[ch_reg*3 +: 3];
		sel = logical_source_select[ch_reg*8 +: 8];
		par0 = logical_function_parameter[ch_reg*64 +: 32];
		par1 = logical_function_parameter[ch_reg*64+32 +: 32];
		src0 = pick({4'h0, sel[3:0]}, phys_values,
			res_reg[(sel[2:0] < NCH) ? sel[2:0] : 3'h0],
			function_select[((sel[2:0] < NCH) ? sel[2:0] : 3'h0)*3 +: 3]);
		src1 = pick({4'h0, sel[7:4]}, phys_values,
			res_reg[(sel[6:4] < NCH) ? sel[6:4] : 3'h0],
			function_select[((sel[6:4] < NCH) ? sel[6:4] : 3'h0)*3 +: 3]);
		prod0 = src0 * par0;
		prod1 = src1 * par1;
		// integer times 16.16 lands in 16.16
		add_term = prod0[31:0] + prod1[31:0];
		mprod = (src0 * src1) * par0;
		mul_term = mprod[47:16];
		new_res = res_reg[ch_reg];
		case (fn)
			`LCMU_FN_ADD: begin
				new_res = add_term;
			end
			`LCMU_FN_INT_ADD: begin
				new_res = res_reg[ch_reg] + add_term;
			end
			`LCMU_FN_MUL: begin
				new_res = mul_term;
			end
			`LCMU_FN_INT_MUL: begin
				new_res = res_reg[ch_reg] + mul_term;
			end
			`LCMU_FN_CMP: begin
				if (src0 > src1)
					new_res = 32'h0000_0001;
				else if (src0 < src1)
					new_res = 32'h0000_0000;
			end
			`LCMU_FN_HYST: begin
				if (src0 > $signed(par1[31:16]))
					new_res = 32'h0000_0001;
				else if (src0 < $signed(par0[31:16]))
					new_res = 32'h0000_0000;
			end
			default: begin
				new_res = res_reg[ch_reg];
			end
		endcase
	end

	// ================================================================
	// execution sequencer
	always @(posedge clock) begin
		if (!rst_b) begin
			ex_state_reg <= EX_IDLE;
			ch_reg <= 3'h0;
			exec_pend_reg <= 1'b0;
			sample_update_counter_reg <= `LCMU_COUNT_RST;
			for (k = 0; k < NCH; k = k + 1) begin
				res_reg[k] <= `LCMU_RESULT_RST;
			end
		end else begin
			if (exec_tick)
				exec_pend_reg <= 1'b1;
			case (ex_state_reg)
				EX_IDLE: begin
					if ((exec_pend_reg || exec_tick) &&
						fr_state_reg == FR_IDLE && !frame_pend_reg &&
						!frame_req) begin
						exec_pend_reg <= 1'b0;
						ch_reg <= 3'h0;
						ex_state_reg <= EX_EVAL;
					end
				end
				EX_EVAL: begin
					res_reg[ch_reg] <= new_res;
					if (ch_reg == NCH - 1)
						ex_state_reg <= EX_SHIFT;
					else
						ch_reg <= ch_reg + 3'h1;
				end
				EX_SHIFT: begin
					sample_update_counter_reg <=
						sample_update_counter_reg + 8'h01;
					ex_state_reg <= EX_IDLE;
				end
				default: begin
					ex_state_reg <= EX_IDLE;
				end
			endcase
		end
	end

	// ================================================================
	// transfer slot decode
	always @* begin
		slot = slot_map[slot_idx_reg*`LCMU_SLOT_W +: `LCMU_SLOT_W];
		slot_ch = slot[`LCMU_SLOT_CH_LSB +: 3];
		slot_word = 16'h0000;
		for (j = 0; j < NCH; j = j + 1) begin
			if (slot_ch == j) begin
				if (function_select[j*3 +: 3] == `LCMU_FN_CMP ||
					function_select[j*3 +: 3] == `LCMU_FN_HYST)
					slot_word = bits[j];
				// low word only in 32-bit mode
				else if (wide32_select[j] && slot[`LCMU_SLOT_LOW_BIT])
					slot_word = rd_data[j][15:0];
				else
					slot_word = rd_data[j][31:16];
			end
		end
	end

	// ================================================================
	// transfer frame sequencer
	always @(posedge clock) begin
		if (!rst_b) begin
			fr_state_reg <= FR_IDLE;
			slot_idx_reg <= 4'h0;
			frame_pend_reg <= 1'b0;
			frame_word_reg <= 16'h0000;
			frame_valid_reg <= 1'b0;
			frame_last_reg <= 1'b0;
			missed_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			frame_valid_reg <= 1'b0;
			frame_last_reg <= 1'b0;
			busy_reg <= (ex_state_reg != EX_IDLE) ||
				(fr_state_reg != FR_IDLE);
			if (frame_req)
				frame_pend_reg <= 1'b1;
			case (fr_state_reg)
				FR_IDLE: begin
					if ((frame_pend_reg || frame_req) &&
						ex_state_reg == EX_IDLE) begin
						frame_pend_reg <= 1'b0;
						frame_word_reg <= {7'h00, missed_reg,
							sample_update_counter_reg};
						frame_valid_reg <= 1'b1;
						slot_idx_reg <= 4'h0;
						fr_state_reg <= FR_FETCH;
					end
				end
				FR_FETCH: begin
					fr_state_reg <= FR_EMIT;
				end
				FR_EMIT: begin
					frame_word_reg <= slot_word;
					frame_valid_reg <= 1'b1;
					if (slot_idx_reg == NSLOT - 1) begin
						frame_last_reg <= 1'b1;
						fr_state_reg <= FR_IDLE;
					end else begin
						slot_idx_reg <= slot_idx_reg + 4'h1;
						fr_state_reg <= FR_FETCH;
					end
				end
				default: begin
					fr_state_reg <= FR_IDLE;
				end
			endcase
			// tick lost while an update is still pending; set wins
			if (exec_tick && exec_pend_reg)
				missed_reg <= 1'b1;
			else if (fr_state_reg == FR_IDLE &&
				(frame_pend_reg || frame_req) && ex_state_reg == EX_IDLE)
				missed_reg <= 1'b0;
		end
	end

endmodule // lcmu_top

`default_nettype wire

// ===== test/lcmu_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
module lcmu_top_checker (
	// clock and reset
	input wire clock,
	input wire rst_b,
	// sampling and frame side
	input wire sample_tick,
	input wire [7:0] prescaler,
	input wire frame_req,
	input wire [15:0] frame_word_reg,
	input wire frame_valid_reg,
	input wire frame_last_reg,
	input wire [7:0] sample_update_counter_reg,
	input wire busy_reg
);
	logic [3:0] word_cnt_reg;
	always @(posedge clock) begin
		if (!rst_b || frame_last_reg)
			word_cnt_reg <= 4'h0;
		else if (frame_valid_reg)
			word_cnt_reg <= word_cnt_reg + 4'h1;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence s_gap;
		!frame_valid_reg ##1 frame_valid_reg;
	endsequence
	property p_reset_clear;
		disable iff (1'b0)
		!rst_b |=> sample_update_counter_reg == 8'h00 && !frame_valid_reg;
	endproperty
	property p_count_step;
		$past(rst_b) && $changed(sample_update_counter_reg) |->
		sample_update_counter_reg == $past(sample_update_counter_reg) + 8'h01;
	endproperty
	property p_frame_freeze;
		frame_valid_reg && !frame_last_reg |=> $stable(sample_update_counter_reg);
	endproperty
	property p_gap;
		frame_valid_reg && !frame_last_reg |=> s_gap;
	endproperty
	property p_last_count;
		frame_last_reg |-> frame_valid_reg && word_cnt_reg == 4'he;
	endproperty
	property p_header;
		frame_valid_reg && word_cnt_reg == 4'h0 |->
		frame_word_reg[7:0] == sample_update_counter_reg &&
		frame_word_reg[15:9] == 7'h00;
	endproperty
	property p_frame_answer;
		$rose(frame_req) |-> ##[1:40] frame_valid_reg;
	endproperty
	property p_tick_update;
		sample_tick && prescaler <= 8'h01 && !busy_reg && !frame_req |->
		##[1:12] $changed(sample_update_counter_reg);
	endproperty
	a_reset_clear: assert property (p_reset_clear)
		else $error("no reset clear");
	a_count_step: assert property (p_count_step)
		else $error("counter jump");
	a_frame_freeze: assert property (p_frame_freeze)
		else $error("count moved");
	a_gap: assert property (p_gap)
		else $error("word spacing");
	a_last_count: assert property (p_last_count)
		else $error("frame length");
	a_header: assert property (p_header)
		else $error("bad header");
	a_frame_answer: assert property (p_frame_answer)
		else $error("no frame");
	a_tick_update: assert property (p_tick_update)
		else $error("no update");
endmodule // lcmu_top_checker
bind lcmu_top lcmu_top_checker chk_u (.clock(clock), .rst_b(rst_b),
	.sample_tick(sample_tick), .prescaler(prescaler), .frame_req(frame_req),
	.frame_word_reg(frame_word_reg), .frame_valid_reg(frame_valid_reg),
	.frame_last_reg(frame_last_reg), .busy_reg(busy_reg),
	.sample_update_counter_reg(sample_update_counter_reg));
`default_nettype wire

// ===== test/lcmu_frame_reader.sv
`timescale 1ns/10ps
`default_nettype none
// ====================================================================
// reader that only accepts whole frames
module lcmu_frame_reader (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// bench control
	input wire logic go,
	output logic done,
	// frame side
	input wire logic frame_valid_reg,
	input wire logic frame_last_reg,
	output logic frame_req
);
	logic [4:0] words_reg;
	always @(posedge clock) begin
		if (!rst_b) begin
			frame_req <= 1'b0;
			done <= 1'b0;
			words_reg <= 5'h00;
		end else begin
			frame_req <= go;
			done <= frame_last_reg && words_reg == 5'h0e;
			if (frame_last_reg)
				words_reg <= 5'h00;
			else if (frame_valid_reg)
				words_reg <= words_reg + 5'h01;
		end
	end
endmodule // lcmu_frame_reader
`default_nettype wire

// ===== test/logical_channel_math_unit_test.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; \
	$display("CHECK FAILED %0t got %h want %h", $time, (a), (b)); end end
module logical_channel_math_unit_test;
	reg clock = 1'b0, rst_b = 1'b0, sample_tick = 1'b0, go = 1'b0;
	reg [7:0] prescaler = 8'h00;
	reg [31:0] phys_values = 32'h0;
	reg [17:0] function_select = {3'h3, 3'h5, 3'h1, 3'h4, 3'h2, 3'h0};
	reg [47:0] logical_source_select = 48'h28f8_9890_9898;
	reg [383:0] logical_function_parameter = {64'h1_0000,
		64'h64_0000_ff9c_0000, 64'h1_0000, 64'h0, 64'h1_0000,
		64'hffff_0000_0001_8000};
	reg [5:0] wide32_select = 6'h23;
	reg [111:0] slot_map = 112'h34_70_0f_02_d0_50_40_b0_30_20_90_10_80_00;
	wire frame_req, frame_valid_reg, frame_last_reg, busy_reg, done;
	wire [15:0] frame_word_reg;
	wire [7:0] sample_update_counter_reg;
	logic [31:0] hist [0:5][0:15];
	logic [31:0] cur [0:5];
	logic [15:0] exp_q [$];
	logic [15:0] got_w;
	logic miss = 1'b0;
	int err_total = 0, tests_run = 0, execs = 0;
	lcmu_top dut_u (.clock(clock), .rst_b(rst_b), .sample_tick(sample_tick),
		.prescaler(prescaler), .phys_values(phys_values),
		.function_select(function_select), .wide32_select(wide32_select),
		.logical_source_select(logical_source_select),
		.logical_function_parameter(logical_function_parameter),
		.slot_map(slot_map), .frame_req(frame_req),
		.frame_word_reg(frame_word_reg), .frame_valid_reg(frame_valid_reg),
		.frame_last_reg(frame_last_reg), .busy_reg(busy_reg),
		.sample_update_counter_reg(sample_update_counter_reg));
	lcmu_frame_reader reader_u (.clock(clock), .rst_b(rst_b), .go(go),
		.done(done), .frame_valid_reg(frame_valid_reg),
		.frame_last_reg(frame_last_reg), .frame_req(frame_req));
	initial begin
		forever #5 clock = ~clock;
	end
	function automatic logic [15:0] srcv(input logic [3:0] s, input int n);
		int m;
		m = (s[2:0] > 3'h5) ? 0 : s[2:0];
		if (s[3])
			return (s[2:0] < 3'h2) ? phys_values[16*s[2:0] +: 16] : 16'h0;
		if (function_select[3*m +: 3] >= 3'h4)
			return {15'h0, (m < n) ? cur[m][0] : hist[m][0][0]};
		return (m < n) ? cur[m][31:16] : hist[m][0][31:16];
	endfunction
	task model_exec;
		logic signed [15:0] a, b;
		logic signed [31:0] p0, p1, h;
		logic signed [63:0] t;
		for (int n = 0; n < 6; n++) begin
			a = srcv(logical_source_select[8*n +: 4], n);
			b = srcv(logical_source_select[8*n+4 +: 4], n);
			{p1, p0} = logical_function_parameter[64*n +: 64];
			h = hist[n][0];
			t = a * b * p0;
			case (function_select[3*n +: 3])
			3'h0: cur[n] = a * p0 + b * p1;
			3'h1: cur[n] = h + a * p0 + b * p1;
			3'h2: cur[n] = t[47:16];
			3'h3: cur[n] = h + $signed(t[47:16]);
			3'h4: cur[n] = {31'h0, (a > b) | ((a == b) & h[0])};
			default: cur[n] = {31'h0, (a > $signed(p1[31:16])) |
				((a >= $signed(p0[31:16])) & h[0])};
			endcase
			for (int l = 15; l > 0; l--)
				hist[n][l] = hist[n][l-1];
			hist[n][0] = cur[n];
		end
		execs++;
	endtask
	task note_frame;
		logic [7:0] d;
		logic [15:0] w;
		exp_q.push_back({7'h00, miss, execs[7:0]});
		miss = 1'b0;
		for (int i = 0; i < 14; i++) begin
			d = slot_map[8*i +: 8];
			if (d[6:4] > 3'h5)
				w = 16'h0;
			else if (function_select[3*d[6:4] +: 3] >= 3'h4)
				for (int l = 0; l < 16; l++)
					w[l] = hist[d[6:4]][l][0];
			else if (d[7] && wide32_select[d[6:4]])
				w = hist[d[6:4]][d[3:0]][15:0];
			else
				w = hist[d[6:4]][d[3:0]][31:16];
			exp_q.push_back(w);
		end
	endtask
	task do_reset(input int n);
		@(posedge clock) rst_b <= 1'b0;
		repeat (n) @(posedge clock);
		rst_b <= 1'b1;
		foreach (hist[c, l])
			hist[c][l] = 32'h0;
		execs = 0;
	endtask
	task do_tick(input bit ex);
		@(posedge clock) sample_tick <= 1'b1;
		@(posedge clock) sample_tick <= 1'b0;
		if (ex)
			model_exec();
		repeat (2) @(posedge clock);
		`CHK(busy_reg, ex)
		repeat (10) @(posedge clock);
		`CHK(busy_reg, 1'b0)
	endtask
	task do_frame;
		int n;
		note_frame();
		@(posedge clock) go <= 1'b1;
		@(posedge clock) go <= 1'b0;
		n = 0;
		while (done !== 1'b1 && n < 60) begin
			@(posedge clock);
			n++;
		end
		if (n >= 60) begin
			err_total++;
			$display("CHECK FAILED %0t frame timeout", $time);
		end
		@(posedge clock);
	endtask
	always @(posedge clock) begin
		if (frame_valid_reg === 1'b1) begin
			got_w = exp_q.size() ? exp_q.pop_front() : 16'hdead;
			`CHK(frame_word_reg, got_w)
			if (frame_last_reg === 1'b1)
				`CHK(exp_q.size(), 0)
		end
	end
	task close_out;
		if (err_total == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#300000;
		err_total++;
		close_out();
	end
	initial begin
		void'($urandom(32'h4411));
		do_reset(20);
		do_frame();
		for (int k = 0; k < 20; k++) begin
			@(posedge clock);
			phys_values[15:0] <= (k % 5) ? 16'($urandom_range(600) - 300) : 16'h0;
			phys_values[31:16] <= (k % 5) ? 16'($urandom_range(600) - 300) : 16'h0;
			slot_map[111:104] <= {4'h3, 4'($urandom_range(15))};
			do_tick(1'b1);
			if (k % 2)
				do_frame();
		end
		// three ticks two cycles apart: one update, one deferred update, one missed
		repeat (3) begin
			@(posedge clock) sample_tick <= 1'b1;
			@(posedge clock) sample_tick <= 1'b0;
		end
		model_exec();
		model_exec();
		miss = 1'b1;
		repeat (20) @(posedge clock);
		do_frame();
		@(posedge clock) prescaler <= 8'h03;
		for (int t = 1; t <= 6; t++)
			do_tick(t % 3 == 0);
		do_frame();
		prescaler <= 8'h00;
		do_reset(3);
		do_frame();
		close_out();
	end
endmodule // logical_channel_math_unit_test
`default_nettype wire
